// [rtl/ceph_regs.vh]
// register offsets, field positions, reset values and timing counts of the control endpoint
`ifndef CEPH_REGS_VH
`define CEPH_REGS_VH
// command register numbers
`define CEPH_REG_BUF 6'h31
`define CEPH_REG_SETUP 6'h32
`define CEPH_REG_COUNT 6'h33
`define CEPH_REG_XLO 6'h3a
`define CEPH_REG_XHI 6'h3b
`define CEPH_REG_XDAT 6'h3c
// extended address of the toggle register
`define CEPH_XADDR_TOG 16'he683
// command byte fields
`define CEPH_CMD_ADDR 7
`define CEPH_CMD_RD 6
// toggle register fields
`define CEPH_TOG_Q 7
`define CEPH_TOG_S 6
`define CEPH_TOG_R 5
`define CEPH_TOG_IO 4
`define CEPH_TOG_RST 8'h32
// command port timing
`define CEPH_BUSY_NS 50
`define CEPH_CLK_NS 25
`define CEPH_BUSY_CYC ((`CEPH_BUSY_NS + `CEPH_CLK_NS - 1) / `CEPH_CLK_NS)
// packet geometry
`define CEPH_PKT_MAX 8'h40
`endif

// [rtl/ceph_control_endpoint_handler.v]
// control endpoint handler: command decoder, setup store, buffer, toggles
`timescale 1ns/1ps
`include "ceph_regs.vh"

// Function
// - unhandled setup packet raises control-request interrupt, waits for master decision
// - each setup register read returns next stored setup byte, from first
// - any non-zero write to setup register stalls the current request
// - data phase raises buffer interrupt when buffer free (IN) or filled (OUT)
// - requested length from setup bytes six, seven kept; never exceeded
// - short or zero-length IN packet completes status handshake automatically
// - full requested OUT length received and read out of the buffer completes status handshake automatically
// - new unhandled setup before transfer end raises control-request interrupt again
// - standard requests answered locally except endpoint set and clear feature
// - toggle bit 7 reads selected endpoint data toggle
// - toggle bit 6 forces DATA1, bit 5 forces DATA0
// - toggle bit 4 picks direction, bits 3-0 pick endpoint 0,1,2,6,8
// - extended write: low address to extended_addr_low, high to extended_addr_high, data extended_data_window
// - read of extended_data_window returns addressed extended register
// - command byte bit 7 address flag, bit 6 read, nibbles upper first
// - read request answered by asserting active-low interrupt with byte on data
module ceph_control_endpoint_handler #(
    parameter BUF_DEPTH = 64,
    parameter BUSY_CYC = `CEPH_BUSY_CYC
) (
    // clock and reset
    input wire clock,
    input wire resetn,
    // command port
    input wire cmd_strobe,
    input wire [7:0] cmd_byte,
    input wire read_ack,
    output reg ready,
    output reg read_irq_n,
    output reg [7:0] bus_data_low,
    // usb side: setup packets
    input wire setup_valid,
    input wire [63:0] setup_packet,
    input wire setup_auto,
    // usb side: data phase
    input wire usb_in_take,
    input wire usb_out_valid,
    input wire [7:0] usb_out_data,
    input wire usb_out_last,
    input wire usb_in_get,
    input wire [3:0] usb_tog_ep,
    input wire usb_tog_io,
    input wire usb_tog_flip,
    // events toward the master
    output reg control_request_irq,
    output reg control_buffer_irq,
    output reg stall,
    output reg handshake_done,
    output reg in_commit,
    output reg [7:0] in_count,
    output reg [7:0] in_data,
    output reg [7:0] usb_tog_q
);

    localparam ST_IDLE = 2'h0;
    localparam ST_SETUP = 2'h1;
    localparam ST_IN = 2'h2;
    localparam ST_OUT = 2'h3;

    // ==========================================
    // storage
    reg [7:0] setup_mem [0:7];
    reg [7:0] buf_mem [0:BUF_DEPTH-1];
    reg [1:0] state;
    reg [2:0] setup_ptr;
    reg [6:0] wr_ptr;
    reg [6:0] rd_ptr;
    reg [7:0] out_count;
    reg [15:0] remain;
    reg dir_in;
    reg [15:0] xaddr;
    reg [7:0] tog_sel;
    reg [9:0] toggles;
    reg have_addr;
    reg rd_mode;
    reg [5:0] reg_num;
    reg nib_phase;
    reg [3:0] hi_nib;
    reg [7:0] busy;
    reg pending;
    integer i;

    // map endpoint number and direction to a toggle slot
    function [3:0] tog_slot;
        input [3:0] ep;
        input io;
        begin
            case (ep)
                4'h0: tog_slot = 4'h0;
                4'h1: tog_slot = {3'h0, io} + 4'h1;
                4'h2: tog_slot = {3'h0, io} + 4'h3;
                4'h6: tog_slot = {3'h0, io} + 4'h5;
                4'h8: tog_slot = {3'h0, io} + 4'h7;
                default: tog_slot = 4'h9;
            endcase
        end
    endfunction

    wire [3:0] sel_slot = tog_slot(tog_sel[3:0], tog_sel[`CEPH_TOG_IO]);
    wire [3:0] usb_slot = tog_slot(usb_tog_ep, usb_tog_io);
    wire is_ep_feature = (setup_packet[4:0] == 5'h02)
                         && ((setup_packet[15:8] == 8'h01) || (setup_packet[15:8] == 8'h03));
    wire take = cmd_strobe && ready;
    wire data_done = take && !cmd_byte[`CEPH_CMD_ADDR] && have_addr && !rd_mode && nib_phase;
    wire [7:0] wdata = {hi_nib, cmd_byte[3:0]};
    wire rd_req = take && cmd_byte[`CEPH_CMD_ADDR] && cmd_byte[`CEPH_CMD_RD];
    wire [7:0] sel_read = {toggles[sel_slot], 2'b00, tog_sel[4:0]};
    // the edge on which a read answer is put out; read pointers step here, not at the request
    wire answer = pending && (busy == 8'h00) && read_irq_n;

    // ==========================================
    // command decoder: ready, nibble assembly and read answers
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ready <= 1'b0;
            busy <= 8'h01;
            have_addr <= 1'b0;
            rd_mode <= 1'b0;
            reg_num <= 6'h00;
            nib_phase <= 1'b0;
            hi_nib <= 4'h0;
            pending <= 1'b0;
            read_irq_n <= 1'b1;
            bus_data_low <= 8'h00;
        end else begin
            if (take) begin
                ready <= 1'b0;
                busy <= BUSY_CYC[7:0];
            end else if (busy != 8'h00) begin
                busy <= busy - 8'h01;
            end else if (!pending) begin
                ready <= 1'b1;
            end
            if (take && cmd_byte[`CEPH_CMD_ADDR]) begin
                // a fresh address drops any half-sent data byte
                have_addr <= 1'b1;
                rd_mode <= cmd_byte[`CEPH_CMD_RD];
                reg_num <= cmd_byte[5:0];
                nib_phase <= 1'b0;
                pending <= cmd_byte[`CEPH_CMD_RD];
            end else if (take && have_addr && !rd_mode) begin
                nib_phase <= !nib_phase;
                if (!nib_phase) begin
                    hi_nib <= cmd_byte[3:0];
                end
            end
            if (answer) begin
                read_irq_n <= 1'b0;
                case (reg_num)
                    `CEPH_REG_BUF: bus_data_low <= buf_mem[rd_ptr[5:0]];
                    `CEPH_REG_SETUP: bus_data_low <= setup_mem[setup_ptr];
                    `CEPH_REG_COUNT: bus_data_low <= out_count;
                    `CEPH_REG_XDAT: bus_data_low <= (xaddr == `CEPH_XADDR_TOG) ?
                                                    sel_read : 8'h00;
                    default: bus_data_low <= 8'h00;
                endcase
            end else if (!read_irq_n && read_ack) begin
                read_irq_n <= 1'b1;
                pending <= 1'b0;
            end
        end
    end

    // ==========================================
    // extended address window and toggle register
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            xaddr <= 16'h0000;
            tog_sel <= `CEPH_TOG_RST;
            toggles <= 10'h000;
        end else begin
            if (usb_tog_flip) begin
                toggles[usb_slot] <= !toggles[usb_slot];
            end
            if (data_done && reg_num == `CEPH_REG_XLO) begin
                xaddr[7:0] <= wdata;
            end
            if (data_done && reg_num == `CEPH_REG_XHI) begin
                xaddr[15:8] <= wdata;
            end
            if (data_done && reg_num == `CEPH_REG_XDAT && xaddr == `CEPH_XADDR_TOG) begin
                tog_sel <= {3'h0, wdata[4:0]};
                // forcing acts on the slot chosen by the selection written with it
                if (wdata[`CEPH_TOG_S]) begin
                    toggles[tog_slot(wdata[3:0], wdata[`CEPH_TOG_IO])] <= 1'b1;
                end else if (wdata[`CEPH_TOG_R]) begin
                    toggles[tog_slot(wdata[3:0], wdata[`CEPH_TOG_IO])] <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // control transfer sequencing
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            setup_ptr <= 3'h0;
            wr_ptr <= 7'h00;
            rd_ptr <= 7'h00;
            out_count <= 8'h00;
            remain <= 16'h0000;
            dir_in <= 1'b0;
            control_request_irq <= 1'b0;
            control_buffer_irq <= 1'b0;
            stall <= 1'b0;
            handshake_done <= 1'b0;
            in_commit <= 1'b0;
            in_count <= 8'h00;
            in_data <= 8'h00;
            usb_tog_q <= 8'h00;
            for (i = 0; i < 8; i = i + 1) begin
                setup_mem[i] <= 8'h00;
            end
        end else begin
            handshake_done <= 1'b0;
            in_commit <= 1'b0;
            usb_tog_q <= {7'h00, toggles[usb_slot]};
            if (usb_in_get) begin
                in_data <= buf_mem[rd_ptr[5:0]];
                rd_ptr <= rd_ptr + 7'h01;
            end
            if (setup_valid) begin
                for (i = 0; i < 8; i = i + 1) begin
                    setup_mem[i] <= setup_packet[8*i +: 8];
                end
                setup_ptr <= 3'h0;
                stall <= 1'b0;
                wr_ptr <= 7'h00;
                rd_ptr <= 7'h00;
                remain <= setup_packet[63:48];
                dir_in <= setup_packet[7];
                control_buffer_irq <= 1'b0;
                if (!setup_auto || is_ep_feature) begin
                    control_request_irq <= 1'b1;
                    state <= ST_SETUP;
                end else begin
                    state <= ST_IDLE;
                end
            end else begin
                if (rd_req && cmd_byte[5:0] == `CEPH_REG_SETUP) begin
                    control_request_irq <= 1'b0;
                end
                // stepping at the answer keeps the first byte handed out as byte zero
                if (answer && reg_num == `CEPH_REG_SETUP) begin
                    setup_ptr <= setup_ptr + 3'h1;
                end
                if (data_done && reg_num == `CEPH_REG_SETUP && wdata != 8'h00) begin
                    stall <= 1'b1;
                    state <= ST_IDLE;
                    control_buffer_irq <= 1'b0;
                end else if (data_done && reg_num == `CEPH_REG_BUF && state == ST_IN) begin
                    if (wr_ptr < BUF_DEPTH) begin
                        wr_ptr <= wr_ptr + 7'h01;
                    end
                end else if (data_done && reg_num == `CEPH_REG_COUNT) begin
                    control_buffer_irq <= 1'b0;
                    if (state == ST_SETUP && remain == 16'h0000) begin
                        handshake_done <= 1'b1;
                        state <= ST_IDLE;
                    end else if (state == ST_IN) begin
                        in_commit <= 1'b1;
                        rd_ptr <= 7'h00;
                        wr_ptr <= 7'h00;
                        // clip to what the host asked for
                        in_count <= ({8'h00, wdata} > remain) ? remain[7:0] : wdata;
                        remain <= ({8'h00, wdata} > remain) ? 16'h0000 :
                                  remain - {8'h00, wdata};
                        if (wdata < `CEPH_PKT_MAX || {8'h00, wdata} >= remain) begin
                            handshake_done <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                if (state == ST_SETUP && remain != 16'h0000 && !control_request_irq) begin
                    state <= dir_in ? ST_IN : ST_OUT;
                    control_buffer_irq <= dir_in;
                end
                if (state == ST_IN && usb_in_take) begin
                    control_buffer_irq <= 1'b1;
                end
                // buffer read clears the flag before a new packet may set it again
                if (rd_req && cmd_byte[5:0] == `CEPH_REG_BUF && state == ST_OUT) begin
                    control_buffer_irq <= 1'b0;
                end
                if (answer && reg_num == `CEPH_REG_BUF && state == ST_OUT) begin
                    rd_ptr <= rd_ptr + 7'h01;
                end
                if (state == ST_OUT && usb_out_valid && remain != 16'h0000) begin
                    buf_mem[wr_ptr[5:0]] <= usb_out_data;
                    wr_ptr <= wr_ptr + 7'h01;
                    remain <= remain - 16'h0001;
                    if (usb_out_last) begin
                        out_count <= {1'b0, wr_ptr} + 8'h01;
                        control_buffer_irq <= 1'b1;
                    end
                end
                if (state == ST_OUT && remain == 16'h0000 && rd_ptr[6:0] == out_count[6:0]) begin
                    handshake_done <= 1'b1;
                    state <= ST_IDLE;
                end
            end
            if (data_done && reg_num == `CEPH_REG_BUF && state == ST_IN
                    && wr_ptr < BUF_DEPTH) begin
                buf_mem[wr_ptr[5:0]] <= wdata;
            end
        end
    end

endmodule

// [tb/ceph_checker_assertions.sv]
// checker of command port timing and setup event outputs
`timescale 1ns/1ps
module ceph_checker (
    // clock and reset
    input wire clock,
    input wire resetn,
    // command port
    input wire cmd_strobe,
    input wire [7:0] cmd_byte,
    input wire read_ack,
    input wire ready,
    input wire read_irq_n,
    input wire [7:0] bus_data_low,
    // usb side and events
    input wire setup_valid,
    input wire [63:0] setup_packet,
    input wire setup_auto,
    input wire control_request_irq,
    input wire stall,
    input wire handshake_done,
    input wire in_commit,
    input wire [7:0] in_count
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // ==========================================
    // helpers
    wire take = cmd_strobe && ready;
    wire rd_take = take && cmd_byte[7] && cmd_byte[6];
    // endpoint set or clear feature must reach the master even when auto
    wire feat = setup_packet[6:0] == 7'h02
                && (setup_packet[15:8] == 8'h01 || setup_packet[15:8] == 8'h03);
    sequence s_busy;
        !ready ##1 !ready;
    endsequence
    sequence s_forward;
        setup_valid && (!setup_auto || feat);
    endsequence
    // ==========================================
    // properties
    property p_busy;
        take && !rd_take |=> s_busy ##1 !ready ##1 ready;
    endproperty
    property p_rd_irq;
        rd_take |-> ##[1:6] !read_irq_n;
    endproperty
    property p_rd_hold;
        !read_irq_n && !read_ack |=> !read_irq_n && $stable(bus_data_low);
    endproperty
    property p_rd_rel;
        !read_irq_n && read_ack |-> ##[1:2] read_irq_n;
    endproperty
    property p_rd_gate;
        !read_irq_n |-> !ready;
    endproperty
    property p_req;
        s_forward |-> ##[1:2] control_request_irq;
    endproperty
    property p_stall_clr;
        setup_valid |-> ##[1:2] !stall;
    endproperty
    property p_clip;
        in_commit |-> in_count <= 8'h40;
    endproperty
    property p_hs;
        handshake_done |=> !handshake_done;
    endproperty
    a_busy: assert property (p_busy) else $error("ready pause wrong");
    a_rd_irq: assert property (p_rd_irq) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read answer moved");
    a_rd_rel: assert property (p_rd_rel) else $error("read not released");
    a_rd_gate: assert property (p_rd_gate) else $error("ready high in read");
    a_req: assert property (p_req) else $error("no request irq");
    a_stall_clr: assert property (p_stall_clr) else $error("stall kept");
    a_clip: assert property (p_clip) else $error("in count too big");
    a_hs: assert property (p_hs) else $error("handshake pulse long");
endmodule
bind ceph_control_endpoint_handler ceph_checker u_chk (.clock, .resetn, .cmd_strobe, .cmd_byte,
    .read_ack, .ready, .read_irq_n, .bus_data_low, .setup_valid, .setup_packet, .setup_auto,
    .control_request_irq, .stall, .handshake_done, .in_commit, .in_count);

// [tb/ceph_master.sv]
// model of the external master driving the nibble command port
`timescale 1ns/1ps
module ceph_master (
    // clock
    input wire clock,
    // command port
    output logic cmd_strobe,
    output logic [7:0] cmd_byte,
    output logic read_ack,
    input wire ready,
    input wire read_irq_n,
    input wire [7:0] bus_data_low
);
    // ==========================================
    // idle drive; a released bus shows the inverse, never the old byte
    initial begin
        cmd_strobe = 1'b0;
        cmd_byte = 8'hff;
        read_ack = 1'b0;
    end
    // one byte, raised once ready is seen high or after 400 cycles, held over the taking edge
    task send(input logic [7:0] b);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 400) begin
            @(posedge clock);
            #2;
            n++;
        end
        cmd_byte = b;
        cmd_strobe = 1'b1;
        @(posedge clock);
        #2;
        cmd_strobe = 1'b0;
        cmd_byte = ~b;
        @(posedge clock);
        #2;
    endtask
    // register write: address byte then upper and lower nibble
    task wr(input logic [5:0] r, input logic [7:0] d);
        send({2'b10, r});
        send({4'h0, d[7:4]});
        send({4'h0, d[3:0]});
    endtask
    // register read: wait for the active-low answer, then acknowledge
    task rd(input logic [5:0] r, output logic [7:0] d);
        int n;
        send({2'b11, r});
        n = 0;
        while (read_irq_n !== 1'b0 && n < 400) begin
            @(posedge clock);
            #2;
            n++;
        end
        // a slow master: the answer must stand one more edge before the acknowledge
        @(posedge clock);
        #2;
        d = bus_data_low;
        read_ack = 1'b1;
        @(posedge clock);
        #2;
        read_ack = 1'b0;
    endtask
endmodule

// [tb/test_control_endpoint_handler.sv]
// self-checking bench of the control endpoint handler
`timescale 1ns/1ps
module test_control_endpoint_handler;
    reg clock, resetn, setup_valid, setup_auto, usb_in_take, usb_out_valid, usb_out_last;
    reg usb_in_get, usb_tog_io, usb_tog_flip;
    reg [63:0] setup_packet;
    reg [7:0] usb_out_data;
    reg [3:0] usb_tog_ep;
    wire cmd_strobe, read_ack, ready, read_irq_n, control_request_irq, control_buffer_irq;
    wire stall, handshake_done, in_commit;
    wire [7:0] cmd_byte, bus_data_low, in_count, in_data, usb_tog_q;
    int errors, cmp_count, cycles, i;
    logic hs_seen;
    logic [7:0] got, last_count;
    // ==========================================
    // instances
    ceph_control_endpoint_handler #(.BUF_DEPTH(64), .BUSY_CYC(2)) dut (.clock, .resetn,
        .cmd_strobe, .cmd_byte, .read_ack, .ready, .read_irq_n, .bus_data_low, .setup_valid,
        .setup_packet, .setup_auto, .usb_in_take, .usb_out_valid, .usb_out_data, .usb_out_last,
        .usb_in_get, .usb_tog_ep, .usb_tog_io, .usb_tog_flip, .control_request_irq,
        .control_buffer_irq, .stall, .handshake_done, .in_commit, .in_count, .in_data, .usb_tog_q);
    ceph_master master (.clock, .cmd_strobe, .cmd_byte, .read_ack, .ready, .read_irq_n,
        .bus_data_low);
    // ==========================================
    // clock, event capture and hang limit of about twenty times the expected run
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (handshake_done === 1'b1) hs_seen <= 1'b1;
        if (in_commit === 1'b1) last_count <= in_count;
        if (cycles > 8000) begin
            errors++;
            print_verdict();
        end
    end
    task chk8(input string what, input logic [7:0] exp, input logic [7:0] act);
        cmp_count++;
        if (act !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, act);
        end
    endtask
    task rdc(input logic [5:0] r, input logic [7:0] exp, input string what);
        master.rd(r, got);
        chk8(what, exp, got);
    endtask
    task tick(input int n);
        repeat (n) begin
            @(posedge clock);
            #2;
        end
    endtask
    task setup(input logic [63:0] p, input logic a);
        setup_packet = p;
        setup_auto = a;
        setup_valid = 1'b1;
        tick(1);
        setup_valid = 1'b0;
        tick(2);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        {setup_valid, setup_auto, usb_in_take, usb_out_valid, usb_out_last} = 5'h00;
        {usb_in_get, usb_tog_flip, usb_out_data, setup_packet} = 74'h0;
        usb_tog_ep = 4'h6;
        usb_tog_io = 1'b1;
        resetn = 1'b0;
        {errors, cmp_count, cycles, hs_seen, last_count} = 0;
        tick(4);
        resetn = 1'b1;
        chk8("irq idle", 8'h01, {7'h00, read_irq_n});
        master.wr(6'h3a, 8'h83);
        master.wr(6'h3b, 8'he6);
        rdc(6'h3c, 8'h12, "toggle reset");
        master.wr(6'h3c, 8'h16);
        master.wr(6'h3c, 8'h56);
        rdc(6'h3c, 8'h96, "toggle set");
        chk8("usb toggle", 8'h01, {7'h00, usb_tog_q[0]});
        usb_tog_flip = 1'b1;
        tick(1);
        usb_tog_flip = 1'b0;
        rdc(6'h3c, 8'h16, "toggle flip");
        master.wr(6'h3c, 8'h56);
        master.wr(6'h3c, 8'h36);
        rdc(6'h3c, 8'h16, "toggle clear");
        $display("test toggle done");
        // out transfer of three bytes
        setup(64'h0003000000000540, 1'b0);
        chk8("request irq", 8'h01, {7'h00, control_request_irq});
        for (i = 0; i < 8; i++) rdc(6'h32, setup_packet[i*8 +: 8], "setup byte");
        chk8("request clear", 8'h00, {7'h00, control_request_irq});
        hs_seen = 1'b0;
        for (i = 0; i < 3; i++) begin
            {usb_out_valid, usb_out_last, usb_out_data} = {1'b1, i == 2, 8'ha0 + 8'(i)};
            tick(1);
        end
        {usb_out_valid, usb_out_last} = 2'b00;
        tick(2);
        chk8("out buffer irq", 8'h01, {7'h00, control_buffer_irq});
        rdc(6'h33, 8'h03, "out count");
        for (i = 0; i < 3; i++) rdc(6'h31, 8'ha0 + 8'(i), "out byte");
        chk8("out handshake", 8'h01, {7'h00, hs_seen});
        $display("test out done");
        // in transfer, restarted by a second setup, three bytes clipped to two
        setup(64'h00020000000006c0, 1'b0);
        rdc(6'h32, 8'hc0, "in setup");
        chk8("in buffer irq", 8'h01, {7'h00, control_buffer_irq});
        setup(64'h00020000000006c0, 1'b0);
        chk8("repeat irq", 8'h01, {7'h00, control_request_irq});
        rdc(6'h32, 8'hc0, "pointer restart");
        hs_seen = 1'b0;
        for (i = 0; i < 3; i++) master.wr(6'h31, 8'h11 * 8'(i + 1));
        master.wr(6'h33, 8'h03);
        tick(2);
        chk8("in count", 8'h02, last_count);
        chk8("in handshake", 8'h01, {7'h00, hs_seen});
        usb_in_get = 1'b1;
        tick(1);
        usb_in_get = 1'b0;
        tick(1);
        chk8("in data", 8'h11, in_data);
        // a full packet keeps the phase open past the host freeing the buffer, until a zero-length packet
        setup(64'h00800000000006c0, 1'b0);
        rdc(6'h32, 8'hc0, "long setup");
        hs_seen = 1'b0;
        master.wr(6'h33, 8'h40);
        chk8("full count", 8'h40, last_count);
        chk8("full open", 8'h00, {7'h00, hs_seen});
        chk8("full no irq", 8'h00, {7'h00, control_buffer_irq});
        usb_in_take = 1'b1;
        tick(1);
        usb_in_take = 1'b0;
        tick(1);
        chk8("refill irq", 8'h01, {7'h00, control_buffer_irq});
        master.wr(6'h33, 8'h00);
        tick(2);
        chk8("zero packet", 8'h00, last_count);
        chk8("zero handshake in", 8'h01, {7'h00, hs_seen});
        $display("test in done");
        // stall, forwarded feature, zero count, automatic request
        setup(64'h0000000000000140, 1'b0);
        rdc(6'h32, 8'h40, "stall setup");
        master.wr(6'h32, 8'h01);
        chk8("stall", 8'h01, {7'h00, stall});
        setup(64'h0000000000000102, 1'b1);
        chk8("feature irq", 8'h01, {7'h00, control_request_irq});
        chk8("stall clear", 8'h00, {7'h00, stall});
        hs_seen = 1'b0;
        master.wr(6'h33, 8'h00);
        tick(2);
        chk8("zero handshake", 8'h01, {7'h00, hs_seen});
        rdc(6'h32, 8'h02, "feature byte");
        setup(64'h0012000001000680, 1'b1);
        chk8("auto request", 8'h00, {7'h00, control_request_irq});
        $display("test setup done");
        print_verdict();
    end
endmodule
